//--- bench/sdb_remote_uart.sv
// Far-side serial partner: drives the receive and clear-to-send pins.
// Assumes the bench sets its levels; undriven pins are pulled up.
`timescale 1ns/1ns
`default_nettype none
module sdb_remote_uart
   import sdb_pkg::*;
#(
   parameter int CTS_PIN = 5,
   parameter int RXD_PIN = 6
)
(
   // Commands
   input wire logic ctsOn,
   input wire logic rxdBit,
   // Pins
   input wire logic [NUM_PINS-1:0] pinOut,
   input wire logic [NUM_PINS-1:0] pinOe,
   output logic [NUM_PINS-1:0] pinIn
);
   always_comb
   begin
      pinIn = pinOut | ~pinOe;
      pinIn[CTS_PIN] = ~ctsOn;
      pinIn[RXD_PIN] = rxdBit;
   end
endmodule : sdb_remote_uart
`default_nettype wire

//--- bench/tb_sdb_regs.sv
// Self-checking bench for the register slave and pin routing.
// Assumes an AXI4-Lite slave answering after its own handshakes.
`timescale 1ns/1ns
`default_nettype none
module tb_sdb_regs
   import sdb_pkg::*;
;
   logic mclk = 0, reset_n = 0, awv = 0, wv = 0, arv = 0, awr, wr_, arr, bv, rv;
   logic rxS = 0, txS = 0, txdLevel = 1, ctsOn = 0, rxdBit = 1;
   logic rxdLevel, rxEnable, txEnable, rxFlushReq, irq;
   logic [11:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rdat, bitRate, pinIn, pinOut, pinOe, d;
   logic [3:0] lineError = 0;
   logic [2:0] parityMode;
   logic [1:0] br, rr, r, bRsp;
   int mismatches = 0, checks = 0, cyc = 0, flushSeen = 0;
   always #20 mclk = ~mclk;
   // Counts cycles in which the flush request stands
   always @(negedge mclk) flushSeen += rxFlushReq;
   sdb_regs sdb_regs_inst (.mclk(mclk), .reset_n(reset_n), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
      .rxByteStrobe(rxS), .txByteStrobe(txS), .lineError(lineError), .txdLevel(txdLevel),
      .rxdLevel(rxdLevel), .rxEnable(rxEnable), .txEnable(txEnable),
      .rxFlushReq(rxFlushReq), .bitRate(bitRate), .parityMode(parityMode),
      .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .irq(irq));
   sdb_remote_uart sdb_remote_uart_inst (.ctsOn(ctsOn), .rxdBit(rxdBit),
      .pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn));
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : summarize
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         mismatches++;
         summarize();
      end
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      logic ta, tw, tb;
      awa <= a; wd <= v; awv <= 1; wv <= 1;
      do begin
         @(negedge mclk); ta = awv & awr; tw = wv & wr_; tb = bv; bRsp = br;
         @(posedge mclk); if (ta) awv <= 0; if (tw) wv <= 0;
      end while (!tb);
   endtask : wr
   task automatic rd(input logic [11:0] a);
      logic ta, tb;
      ara <= a; arv <= 1;
      do begin
         @(negedge mclk); ta = arr;
         @(posedge mclk); if (ta) arv <= 0;
      end while (!ta);
      do begin
         @(negedge mclk); tb = rv; d = rdat; r = rr;
         @(posedge mclk);
      end while (!tb);
   endtask : rd
   task automatic rc(input string n, input logic [11:0] a, input logic [31:0] e);
      rd(a);
      chk(n, d, e);
   endtask : rc
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask : tick
   task automatic t_pins();
      rc("psel reset", OFS_PSEL_RXD, PSEL_RESET);
      chk("rxd idle", rxdLevel, 1'b1);
      wr(OFS_PSEL_TXD, 32'h3); wr(OFS_PSEL_RTS, 32'h4);
      wr(OFS_PSEL_CTS, 32'h5); wr(OFS_PSEL_RXD, 32'h6);
      wr(OFS_ENABLE, 32'h8);
      txdLevel <= 0; rxdBit <= 0;
      tick(2);
      chk("txd oe", pinOe[3], 1'b1);
      chk("txd pin", pinOut[3], 1'b0);
      chk("rxd route", rxdLevel, 1'b0);
      chk("rts idle", pinOut[4], 1'b1);
      wr(OFS_PSEL_TXD, 32'h9);
      rc("psel locked", OFS_PSEL_TXD, 32'h3);
      $display("test pins done");
   endtask : t_pins
   task automatic t_rx();
      wr(OFS_RX_CAP, 32'h2); wr(OFS_START_RX, 32'h1);
      rc("task reads 0", OFS_START_RX, 32'h0);
      chk("rx on", rxEnable, 1'b1);
      lineError <= 4'h5; rxS <= 1; tick(1); lineError <= 0; tick(2); rxS <= 0; tick(1);
      rc("rx amount", OFS_RX_AMOUNT, 32'h2);
      chk("rx off", rxEnable, 1'b0);
      rc("end rx ev", 12'h110, 32'h1);
      rc("err src", OFS_ERRSRC, 32'h5);
      wr(OFS_ERRSRC, 32'h1);
      rc("err w1c", OFS_ERRSRC, 32'h4);
      wr(12'h110, 32'h0);
      rc("ev cleared", 12'h110, 32'h0);
      rc("rdy ev", EVT_OFS[EV_RXDRDY], 32'h1);
      wr(EVT_OFS[EV_RXDRDY], 32'h0);
      rc("rdy cleared", EVT_OFS[EV_RXDRDY], 32'h0);
      wr(OFS_FLUSH_RX, 32'h0);
      rc("flush zero", 12'h110, 32'h0);
      wr(OFS_FLUSH_RX, 32'h1); tick(2);
      rc("flush end", 12'h110, 32'h1);
      chk("flush pulse", flushSeen, 32'h1);
      $display("test rx done");
   endtask : t_rx
   task automatic t_irq();
      wr(OFS_INTERRUPT_ENABLE_SET, 32'h8);
      rc("interrupt_enable set", OFS_INTERRUPT_ENABLE, 32'h8);
      chk("irq on", irq, 1'b1);
      rd(OFS_INT_STATUS); tick(1);
      chk("irq off", irq, 1'b0);
      wr(OFS_INTERRUPT_ENABLE_CLR, 32'h8);
      chk("write okay", bRsp, RESP_OKAY);
      rc("interrupt_enable clr", OFS_INTERRUPT_ENABLE, 32'h0);
      rd(12'h700);
      chk("unmapped", r, RESP_SLVERR);
      wr(12'h700, 32'h1);
      chk("unmapped wr", bRsp, RESP_SLVERR);
      $display("test irq done");
   endtask : t_irq
   task automatic t_tx();
      wr(OFS_CONFIG, 32'h3); wr(OFS_BAUD, 32'h01d7e000);
      chk("parity", parityMode, 3'h1);
      chk("bit rate", bitRate, 32'h01d7e000);
      wr(OFS_TX_LEN, 32'h1); wr(OFS_START_TX, 32'h1); tick(1);
      chk("cts high stalls", txEnable, 1'b0);
      ctsOn <= 1; tick(2);
      chk("cts low sends", txEnable, 1'b1);
      txS <= 1; tick(1); txS <= 0; tick(1);
      rc("tx amount", OFS_TX_AMOUNT, 32'h1);
      rc("cts event", EVT_OFS[EV_CTS], 32'h1);
      rc("tx task 0", OFS_START_TX, 32'h0);
      wr(OFS_START_RX, 32'h1);
      chk("rts asserted", pinOut[4], 1'b0);
      $display("test tx done");
   endtask : t_tx
   initial
   begin
      tick(3);
      reset_n <= 1;
      tick(1);
      t_pins();
      t_rx();
      t_irq();
      t_tx();
      summarize();
   end
endmodule : tb_sdb_regs
`default_nettype wire

//--- design/sdb_pin_mux.sv
// Routes the four serial signals to the general-purpose pins.
// Assumes pin-select values are stable while the block is enabled.
`timescale 1ns/1ns
`default_nettype none
module sdb_pin_mux
   import sdb_pkg::*;
(
   // Control
   input wire logic enabled,
   input wire logic [31:0] pselRts,
   input wire logic [31:0] pselTxd,
   input wire logic [31:0] pselCts,
   input wire logic [31:0] pselRxd,
   // Block side
   input wire logic txdLevel,
   input wire logic rtsLevel,
   output logic rxdLevel,
   output logic ctsLevel,
   // Pins
   input wire logic [NUM_PINS-1:0] pinIn,
   output logic [NUM_PINS-1:0] pinOut,
   output logic [NUM_PINS-1:0] pinOe
);
   logic txdOn;
   logic rtsOn;

   assign txdOn = enabled & ~pselTxd[PSEL_DISC];
   assign rtsOn = enabled & ~pselRts[PSEL_DISC];

   // Idle high on an unrouted input
   assign rxdLevel = (enabled & ~pselRxd[PSEL_DISC]) ? pinIn[pselRxd[PSEL_PIN_W-1:0]] : 1'b1;
   assign ctsLevel = (enabled & ~pselCts[PSEL_DISC]) ? pinIn[pselCts[PSEL_PIN_W-1:0]] : 1'b1;

   // Transmit data wins if both outputs share a pin
   genvar i;
   generate
      for (i = 0; i < NUM_PINS; i++)
      begin : g_pin
         logic txdHere;
         logic rtsHere;
         assign txdHere = txdOn && (pselTxd[PSEL_PIN_W-1:0] == PSEL_PIN_W'(i));
         assign rtsHere = rtsOn && (pselRts[PSEL_PIN_W-1:0] == PSEL_PIN_W'(i));
         assign pinOe[i] = txdHere | rtsHere;
         assign pinOut[i] = txdHere ? txdLevel : (rtsHere ? rtsLevel : 1'b1);
      end
   endgenerate
endmodule : sdb_pin_mux
`default_nettype wire

//--- design/sdb_pkg.sv
// Constants and state type for the serial DMA block register slave.
// Assumes a 32-bit AXI4-Lite master and a 32-pin general-purpose port.
package sdb_pkg;
   localparam int ADDR_W = 12;
   localparam int NUM_PINS = 32;
   localparam int NUM_EV = 11;
   localparam int ERR_W = 4;

   localparam logic [11:0] OFS_START_RX = 12'h000;
   localparam logic [11:0] OFS_STOP_RX = 12'h004;
   localparam logic [11:0] OFS_START_TX = 12'h008;
   localparam logic [11:0] OFS_STOP_TX = 12'h00c;
   localparam logic [11:0] OFS_FLUSH_RX = 12'h02c;
   localparam logic [11:0] OFS_EVENT_TASK_SHORTCUTS = 12'h200;
   localparam logic [11:0] OFS_INTERRUPT_ENABLE = 12'h300;
   localparam logic [11:0] OFS_INTERRUPT_ENABLE_SET = 12'h304;
   localparam logic [11:0] OFS_INTERRUPT_ENABLE_CLR = 12'h308;
   localparam logic [11:0] OFS_ERRSRC = 12'h480;
   localparam logic [11:0] OFS_ENABLE = 12'h500;
   localparam logic [11:0] OFS_PSEL_RTS = 12'h508;
   localparam logic [11:0] OFS_PSEL_TXD = 12'h50c;
   localparam logic [11:0] OFS_PSEL_CTS = 12'h510;
   localparam logic [11:0] OFS_PSEL_RXD = 12'h514;
   localparam logic [11:0] OFS_BAUD = 12'h524;
   localparam logic [11:0] OFS_RX_PTR = 12'h534;
   localparam logic [11:0] OFS_RX_CAP = 12'h538;
   localparam logic [11:0] OFS_RX_AMOUNT = 12'h53c;
   localparam logic [11:0] OFS_TX_PTR = 12'h544;
   localparam logic [11:0] OFS_TX_LEN = 12'h548;
   localparam logic [11:0] OFS_TX_AMOUNT = 12'h54c;
   localparam logic [11:0] OFS_CONFIG = 12'h56c;
   localparam logic [11:0] OFS_INT_STATUS = 12'h600;

   // Event bit positions, shared by events, status and enable layouts
   localparam int EV_CTS = 0;
   localparam int EV_NCTS = 1;
   localparam int EV_RXDRDY = 2;
   localparam int EV_ENDRX = 3;
   localparam int EV_TXDRDY = 4;
   localparam int EV_ENDTX = 5;
   localparam int EV_ERROR = 6;
   localparam int EV_RXTO = 7;
   localparam int EV_RXSTARTED = 8;
   localparam int EV_TXSTARTED = 9;
   localparam int EV_TXSTOPPED = 10;
   localparam logic [11:0] EVT_OFS [NUM_EV] = '{12'h100, 12'h104, 12'h108, 12'h110,
      12'h11c, 12'h120, 12'h124, 12'h144, 12'h14c, 12'h150, 12'h158};

   localparam int SHORT_ENDRX_STARTRX = 0;
   localparam int SHORT_ENDRX_STOPRX = 1;
   localparam int CFG_HWFC = 0;
   localparam int CFG_PAR_LO = 1;
   localparam int PSEL_PIN_W = 5;
   localparam int PSEL_DISC = 31;

   localparam logic [3:0] ENABLE_ON = 4'h8;
   localparam logic [31:0] PSEL_RESET = 32'hffffffff;
   localparam logic [31:0] BAUD_RESET = 32'h00000000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic awHeld;
      logic [11:0] awAddr;
      logic wHeld;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
      logic [NUM_EV-1:0] evt;
      logic [NUM_EV-1:0] intStatus;
      logic [NUM_EV-1:0] interrupt_enable;
      logic [1:0] event_task_shortcuts;
      logic [ERR_W-1:0] errSrc;
      logic [3:0] enable;
      logic [31:0] pselRts;
      logic [31:0] pselTxd;
      logic [31:0] pselCts;
      logic [31:0] pselRxd;
      logic [31:0] baud;
      logic [31:0] rxPtr;
      logic [31:0] rxCap;
      logic [31:0] rxCount;
      logic [31:0] txPtr;
      logic [31:0] txLen;
      logic [31:0] txCount;
      logic [3:0] setup;
      logic rxActive;
      logic txActive;
      logic ctsPrev;
      logic endRxPulse;
      logic flushPulse;
   } sdb_state_t;
endpackage : sdb_pkg

//--- design/sdb_regs.sv
// Register slave, task/event engine and pin routing of the serial DMA block.
// Assumes an AXI4-Lite master on mclk and a serial core that reports bytes.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Each serial signal appears on the pin its pin-select register names, except request-to-send on a pin shared with transmit data.
// - Clear-to-send and request-to-send are low when asserted, high when not.
// - Pin selects act only while enabled; contents lost at reset.
// - Error source is readable; writing one clears a bit, zero keeps it.
// - A nonzero receive capacity bounds bytes written to memory per transfer.
// - Transmit length is the byte count sent per transfer.
// - Amount registers report bytes moved in the latest transfer.
// - One configuration register selects parity and hardware flow control.
// - Bit rate output follows the bit-rate register value.
// - Event registers read one after their event; writing zero clears.
// - Flush requests the leftover bytes and always raises end-of-receive in the same cycle.
module sdb_regs
   import sdb_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // AXI4-Lite write
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Serial core
   input wire logic rxByteStrobe,
   input wire logic txByteStrobe,
   input wire logic [ERR_W-1:0] lineError,
   input wire logic txdLevel,
   output logic rxdLevel,
   output logic rxEnable,
   output logic txEnable,
   output logic rxFlushReq,
   output logic [31:0] bitRate,
   output logic [2:0] parityMode,
   // Pins
   input wire logic [NUM_PINS-1:0] pinIn,
   output logic [NUM_PINS-1:0] pinOut,
   output logic [NUM_PINS-1:0] pinOe,
   // Interrupt
   output logic irq
);
   sdb_state_t q;
   sdb_state_t d;
   logic enabled;
   logic hwfc;
   logic ctsLevel;
   logic ctsAsserted;
   logic rtsLevel;
   logic wrFire;
   logic [31:0] wrVal;
   logic [NUM_EV-1:0] evSet;
   logic startRx;
   logic stopRx;
   logic startTx;
   logic stopTx;
   logic flush;
   logic rdHit;
   logic wrHit;

   function automatic logic [31:0] sdb_merge(logic [31:0] old, logic [31:0] val,
                                             logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
         begin
            r[8*b +: 8] = val[8*b +: 8];
         end
      end
      return r;
   endfunction : sdb_merge

   assign enabled = (q.enable == ENABLE_ON);
   assign hwfc = q.setup[CFG_HWFC];
   assign ctsAsserted = ~ctsLevel;
   assign rtsLevel = ~(hwfc & enabled & q.rxActive);
   assign wrFire = q.awHeld & q.wHeld & ~q.bValid;
   assign wrVal = sdb_merge(32'h00000000, q.wData, q.wStrb);

   sdb_pin_mux u_pin_mux (
      .enabled(enabled),
      .pselRts(q.pselRts),
      .pselTxd(q.pselTxd),
      .pselCts(q.pselCts),
      .pselRxd(q.pselRxd),
      .txdLevel(txdLevel),
      .rtsLevel(rtsLevel),
      .rxdLevel(rxdLevel),
      .ctsLevel(ctsLevel),
      .pinIn(pinIn),
      .pinOut(pinOut),
      .pinOe(pinOe)
   );

   // Tasks fire on a written one while enabled
   assign startRx = enabled & ((wrFire & q.awAddr == OFS_START_RX & q.wData[0])
                    | (q.endRxPulse & q.event_task_shortcuts[SHORT_ENDRX_STARTRX]));
   assign stopRx = enabled & ((wrFire & q.awAddr == OFS_STOP_RX & q.wData[0])
                   | (q.endRxPulse & q.event_task_shortcuts[SHORT_ENDRX_STOPRX]));
   assign startTx = enabled & wrFire & q.awAddr == OFS_START_TX & q.wData[0];
   assign stopTx = enabled & wrFire & q.awAddr == OFS_STOP_TX & q.wData[0];
   assign flush = enabled & wrFire & q.awAddr == OFS_FLUSH_RX & q.wData[0];

   always_comb
   begin
      d = q;
      d.endRxPulse = 1'b0;
      d.flushPulse = 1'b0;
      evSet = '0;
      rdHit = 1'b0;
      wrHit = 1'b0;

      // Write address and data are taken in either order
      if (s_axi_awvalid & s_axi_awready)
      begin
         d.awHeld = 1'b1;
         d.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
         d.wHeld = 1'b1;
         d.wData = s_axi_wdata;
         d.wStrb = s_axi_wstrb;
      end
      if (q.bValid & s_axi_bready)
      begin
         d.bValid = 1'b0;
      end

      if (wrFire)
      begin
         d.awHeld = 1'b0;
         d.wHeld = 1'b0;
         d.bValid = 1'b1;
         for (int i = 0; i < NUM_EV; i++)
         begin
            if (q.awAddr == EVT_OFS[i])
            begin
               d.evt[i] = q.wData[0];
               wrHit = 1'b1;
            end
         end
         case (q.awAddr)
            OFS_START_RX, OFS_STOP_RX, OFS_START_TX, OFS_STOP_TX, OFS_FLUSH_RX,
            OFS_RX_AMOUNT, OFS_TX_AMOUNT, OFS_INT_STATUS:
               wrHit = 1'b1;
            OFS_EVENT_TASK_SHORTCUTS:
            begin
               d.event_task_shortcuts = 2'(sdb_merge({30'h0, q.event_task_shortcuts}, q.wData, q.wStrb));
               wrHit = 1'b1;
            end
            OFS_INTERRUPT_ENABLE:
            begin
               d.interrupt_enable = NUM_EV'(sdb_merge({21'h0, q.interrupt_enable}, q.wData, q.wStrb));
               wrHit = 1'b1;
            end
            OFS_INTERRUPT_ENABLE_SET:
            begin
               d.interrupt_enable = q.interrupt_enable | wrVal[NUM_EV-1:0];
               wrHit = 1'b1;
            end
            OFS_INTERRUPT_ENABLE_CLR:
            begin
               d.interrupt_enable = q.interrupt_enable & ~wrVal[NUM_EV-1:0];
               wrHit = 1'b1;
            end
            OFS_ERRSRC:
            begin
               d.errSrc = q.errSrc & ~wrVal[ERR_W-1:0];
               wrHit = 1'b1;
            end
            OFS_ENABLE:
            begin
               d.enable = 4'(sdb_merge({28'h0, q.enable}, q.wData, q.wStrb));
               wrHit = 1'b1;
            end
            OFS_PSEL_RTS, OFS_PSEL_TXD, OFS_PSEL_CTS, OFS_PSEL_RXD:
            begin
               wrHit = 1'b1;
               if (!enabled)
               begin
                  if (q.awAddr == OFS_PSEL_RTS)
                     d.pselRts = sdb_merge(q.pselRts, q.wData, q.wStrb);
                  if (q.awAddr == OFS_PSEL_TXD)
                     d.pselTxd = sdb_merge(q.pselTxd, q.wData, q.wStrb);
                  if (q.awAddr == OFS_PSEL_CTS)
                     d.pselCts = sdb_merge(q.pselCts, q.wData, q.wStrb);
                  if (q.awAddr == OFS_PSEL_RXD)
                     d.pselRxd = sdb_merge(q.pselRxd, q.wData, q.wStrb);
               end
            end
            OFS_BAUD:
            begin
               d.baud = sdb_merge(q.baud, q.wData, q.wStrb);
               wrHit = 1'b1;
            end
            OFS_RX_PTR:
            begin
               d.rxPtr = sdb_merge(q.rxPtr, q.wData, q.wStrb);
               wrHit = 1'b1;
            end
            OFS_RX_CAP:
            begin
               d.rxCap = sdb_merge(q.rxCap, q.wData, q.wStrb);
               wrHit = 1'b1;
            end
            OFS_TX_PTR:
            begin
               d.txPtr = sdb_merge(q.txPtr, q.wData, q.wStrb);
               wrHit = 1'b1;
            end
            OFS_TX_LEN:
            begin
               d.txLen = sdb_merge(q.txLen, q.wData, q.wStrb);
               wrHit = 1'b1;
            end
            OFS_CONFIG:
            begin
               d.setup = 4'(sdb_merge({28'h0, q.setup}, q.wData, q.wStrb));
               wrHit = 1'b1;
            end
            default:
               ;
         endcase
         d.bResp = wrHit ? RESP_OKAY : RESP_SLVERR;
      end

      // Read port
      if (q.rValid & s_axi_rready)
      begin
         d.rValid = 1'b0;
      end
      if (s_axi_arvalid & s_axi_arready)
      begin
         d.rValid = 1'b1;
         d.rData = '0;
         for (int i = 0; i < NUM_EV; i++)
         begin
            if (s_axi_araddr == EVT_OFS[i])
            begin
               d.rData = {31'h0, q.evt[i]};
               rdHit = 1'b1;
            end
         end
         case (s_axi_araddr)
            OFS_START_RX, OFS_STOP_RX, OFS_START_TX, OFS_STOP_TX, OFS_FLUSH_RX,
            OFS_INTERRUPT_ENABLE_CLR:
               rdHit = 1'b1;
            OFS_EVENT_TASK_SHORTCUTS:
            begin
               d.rData = {30'h0, q.event_task_shortcuts};
               rdHit = 1'b1;
            end
            OFS_INTERRUPT_ENABLE, OFS_INTERRUPT_ENABLE_SET:
            begin
               d.rData = {21'h0, q.interrupt_enable};
               rdHit = 1'b1;
            end
            OFS_ERRSRC:
            begin
               d.rData = {28'h0, q.errSrc};
               rdHit = 1'b1;
            end
            OFS_ENABLE:
            begin
               d.rData = {28'h0, q.enable};
               rdHit = 1'b1;
            end
            OFS_PSEL_RTS:
            begin
               d.rData = q.pselRts;
               rdHit = 1'b1;
            end
            OFS_PSEL_TXD:
            begin
               d.rData = q.pselTxd;
               rdHit = 1'b1;
            end
            OFS_PSEL_CTS:
            begin
               d.rData = q.pselCts;
               rdHit = 1'b1;
            end
            OFS_PSEL_RXD:
            begin
               d.rData = q.pselRxd;
               rdHit = 1'b1;
            end
            OFS_BAUD:
            begin
               d.rData = q.baud;
               rdHit = 1'b1;
            end
            OFS_RX_PTR:
            begin
               d.rData = q.rxPtr;
               rdHit = 1'b1;
            end
            OFS_RX_CAP:
            begin
               d.rData = q.rxCap;
               rdHit = 1'b1;
            end
            OFS_RX_AMOUNT:
            begin
               d.rData = q.rxCount;
               rdHit = 1'b1;
            end
            OFS_TX_PTR:
            begin
               d.rData = q.txPtr;
               rdHit = 1'b1;
            end
            OFS_TX_LEN:
            begin
               d.rData = q.txLen;
               rdHit = 1'b1;
            end
            OFS_TX_AMOUNT:
            begin
               d.rData = q.txCount;
               rdHit = 1'b1;
            end
            OFS_CONFIG:
            begin
               d.rData = {28'h0, q.setup};
               rdHit = 1'b1;
            end
            OFS_INT_STATUS:
            begin
               d.rData = {21'h0, q.intStatus};
               d.intStatus = '0;
               rdHit = 1'b1;
            end
            default:
               ;
         endcase
         d.rResp = rdHit ? RESP_OKAY : RESP_SLVERR;
      end

      // Clear-to-send edges
      d.ctsPrev = enabled & ctsAsserted;
      evSet[EV_CTS] = enabled & ctsAsserted & ~q.ctsPrev;
      evSet[EV_NCTS] = enabled & ~ctsAsserted & q.ctsPrev;

      // Line errors latch until written one
      if (enabled & q.rxActive & |lineError)
      begin
         evSet[EV_ERROR] = 1'b1;
      end
      d.errSrc = d.errSrc | (lineError & {ERR_W{enabled & q.rxActive}});

      // Receive path
      if (startRx)
      begin
         d.rxActive = 1'b1;
         d.rxCount = '0;
         evSet[EV_RXSTARTED] = 1'b1;
      end
      else if (stopRx & q.rxActive)
      begin
         d.rxActive = 1'b0;
         evSet[EV_ENDRX] = 1'b1;
         evSet[EV_RXTO] = 1'b1;
      end
      else if (enabled & q.rxActive & rxByteStrobe)
      begin
         d.rxCount = q.rxCount + 32'h1;
         evSet[EV_RXDRDY] = 1'b1;
         if (q.rxCount + 32'h1 >= q.rxCap)
         begin
            d.rxActive = 1'b0;
            evSet[EV_ENDRX] = 1'b1;
         end
      end
      if (flush)
      begin
         d.flushPulse = 1'b1;
         evSet[EV_ENDRX] = 1'b1;
      end
      d.endRxPulse = evSet[EV_ENDRX];

      // Transmit path
      if (startTx)
      begin
         d.txActive = q.txLen != 32'h0;
         d.txCount = '0;
         evSet[EV_TXSTARTED] = 1'b1;
         evSet[EV_ENDTX] = q.txLen == 32'h0;
      end
      else if (stopTx)
      begin
         d.txActive = 1'b0;
         evSet[EV_TXSTOPPED] = 1'b1;
         evSet[EV_ENDTX] = q.txActive;
      end
      else if (enabled & q.txActive & txByteStrobe)
      begin
         d.txCount = q.txCount + 32'h1;
         evSet[EV_TXDRDY] = 1'b1;
         if (q.txCount + 32'h1 >= q.txLen)
         begin
            d.txActive = 1'b0;
            evSet[EV_ENDTX] = 1'b1;
         end
      end

      // Set wins over any clear in the same cycle
      d.evt = d.evt | evSet;
      d.intStatus = d.intStatus | evSet;
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         q <= '0;
         q.pselRts <= PSEL_RESET;
         q.pselTxd <= PSEL_RESET;
         q.pselCts <= PSEL_RESET;
         q.pselRxd <= PSEL_RESET;
         q.baud <= BAUD_RESET;
      end
      else
      begin
         q <= d;
      end
   end

   assign s_axi_awready = ~q.awHeld & ~q.bValid;
   assign s_axi_wready = ~q.wHeld & ~q.bValid;
   assign s_axi_bvalid = q.bValid;
   assign s_axi_bresp = q.bResp;
   assign s_axi_arready = ~q.rValid;
   assign s_axi_rvalid = q.rValid;
   assign s_axi_rdata = q.rData;
   assign s_axi_rresp = q.rResp;
   assign rxEnable = enabled & q.rxActive;
   assign txEnable = enabled & q.txActive & (~hwfc | ctsAsserted);
   assign rxFlushReq = q.flushPulse;
   assign bitRate = q.baud;
   assign parityMode = q.setup[CFG_PAR_LO +: 3];
   assign irq = |(q.intStatus & q.interrupt_enable);

   a_pins_idle_off: assert property (@(posedge mclk) disable iff (!reset_n)
      !enabled |-> pinOe == '0) else $error("pin driven while disabled");
   a_rts_low_active: assert property (@(posedge mclk) disable iff (!reset_n)
      (hwfc && enabled && q.rxActive) |-> !rtsLevel) else $error("rts not low");
   a_err_one_clears: assert property (@(posedge mclk) disable iff (!reset_n)
      (wrFire && q.awAddr == OFS_ERRSRC && wrVal[0] && !(q.rxActive && lineError[0]))
      |=> !q.errSrc[0]) else $error("error bit not cleared");
   a_flush_end_rx: assert property (@(posedge mclk) disable iff (!reset_n)
      flush |=> (q.evt[EV_ENDRX] && rxFlushReq) ##1 !rxFlushReq)
      else $error("flush without end of receive");
   a_rx_cap_stop: assert property (@(posedge mclk) disable iff (!reset_n)
      (enabled && q.rxActive && rxByteStrobe && !startRx && !stopRx
       && q.rxCount + 32'h1 == q.rxCap) |=> (!q.rxActive && q.evt[EV_ENDRX]))
      else $error("receive overran capacity");
   a_tx_len_stop: assert property (@(posedge mclk) disable iff (!reset_n)
      (enabled && q.txActive && txByteStrobe && !startTx && !stopTx
       && q.txCount + 32'h1 == q.txLen) |=> (!q.txActive && q.evt[EV_ENDTX]))
      else $error("transmit overran length");
   a_amount_counts: assert property (@(posedge mclk) disable iff (!reset_n)
      (enabled && q.rxActive && rxByteStrobe && !startRx && !stopRx)
      |=> q.rxCount == $past(q.rxCount) + 32'h1) else $error("amount not counted");
   a_interrupt_enable_set: assert property (@(posedge mclk) disable iff (!reset_n)
      (wrFire && q.awAddr == OFS_INTERRUPT_ENABLE_SET && wrVal[EV_ENDRX]) |=> q.interrupt_enable[EV_ENDRX])
      else $error("interrupt not enabled");
   a_task_reads_zero: assert property (@(posedge mclk) disable iff (!reset_n)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_START_TX)
      |=> (s_axi_rvalid && s_axi_rdata == 32'h0)) else $error("task read not zero");
   a_event_write: assert property (@(posedge mclk) disable iff (!reset_n)
      (wrFire && q.awAddr == EVT_OFS[EV_RXDRDY] && !q.wData[0] && !evSet[EV_RXDRDY])
      |=> !q.evt[EV_RXDRDY]) else $error("event not cleared");
endmodule : sdb_regs
`default_nettype wire
